// ===== verilog/hpf_follower.sv
// Functional notes
// - Sampling repeats every 50 ms, built from a 0.1 ms sub-tick so the repeat is exact.
// - While enabled, the chosen counter is read once per interval to find the new pulses.
// - An interval with no new counts produces no output pulses.
// - Output pulses equal input pulses times the multiplicand divided by the divisor.
// - The ratio is two settings, multiplicand first and divisor second.
// - The scaled count goes out on the chosen axis at the set speed inside the interval.
// - The counter selector spans 0 to 7, the axis selector 0 to 3, settings are 32 bits.
// - Four working words hold the block's internal state.
// - No pulses go out while the pulse hardware is claimed by another function; the counter is still sampled each interval.
// - The active flag is high exactly while pulses are being emitted.
`timescale 1ns/1ps
`include "hpf_consts.svh"

module hpf_follower #(
  parameter int SUB_TICK_CYCLES = `HPF_SUBTICK_CYCLES,
  parameter int SUBTICKS_PER_SAMPLE = `HPF_SUBTICKS_PER_SAMPLE
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic hwBusy,
  input wire logic [2:0] sourceCounterSel,
  input wire logic [1:0] outputAxisSel,
  input wire hpf_pkg::hpf_counters_t hscCounts,
  input wire hpf_pkg::hpf_settings_t settings,
  output logic [`HPF_NUM_AXES-1:0] pulseOut_ff,
  output logic [`HPF_NUM_AXES-1:0] dirOut_ff,
  output logic pulsingActive_ff,
  output logic sampleTick_ff
);

  localparam int SUB_W = $clog2(SUB_TICK_CYCLES + 1);
  localparam int SMP_W = $clog2(SUBTICKS_PER_SAMPLE + 1);
  localparam int WW = `HPF_WORD_W;
  localparam logic [2*WW-1:0] HALF_CLK = (2*WW)'(`HPF_CLK_HZ / 2);

  generate
    if (SUB_TICK_CYCLES < 1 || SUBTICKS_PER_SAMPLE < 1) begin : g_bad
      $error("hpf_follower: tick counts must be at least one");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Sample pacing
  // --------------------------------------------------------------------------
  logic [SUB_W-1:0] subCnt_ff;
  logic [SMP_W-1:0] smpCnt_ff;
  logic subTick;

  assign subTick = subCnt_ff == SUB_W'(SUB_TICK_CYCLES - 1);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      subCnt_ff <= '0;
      smpCnt_ff <= '0;
      sampleTick_ff <= 1'b0;
    end else begin
      subCnt_ff <= subTick ? '0 : subCnt_ff + SUB_W'(1);
      sampleTick_ff <= 1'b0;
      if (subTick) begin
        if (smpCnt_ff == SMP_W'(SUBTICKS_PER_SAMPLE - 1)) begin
          smpCnt_ff <= '0;
          sampleTick_ff <= 1'b1;
        end else begin
          smpCnt_ff <= smpCnt_ff + SMP_W'(1);
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sampling and scaling operands
  // --------------------------------------------------------------------------
  logic [WW-1:0] workWord_ff [`HPF_WORK_WORDS];
  logic [WW-1:0] curCount;
  logic [WW-1:0] delta;
  logic [WW-1:0] magnitude;
  logic [2*WW-1:0] scaledIn;
  logic go;

  assign curCount = hscCounts[sourceCounterSel];
  assign delta = curCount - workWord_ff[`HPF_WK_PREV];
  // Scaling the magnitude keeps truncation toward zero in both directions.
  assign magnitude = delta[WW-1] ? (~delta + WW'(1)) : delta;
  assign scaledIn = (2*WW)'(magnitude) * (2*WW)'(settings.ratioMultiplicand);
  assign go = enable && !hwBusy && (delta != '0) && (settings.ratioDivisor != '0)
              && (settings.outputSpeed != '0);

  // --------------------------------------------------------------------------
  // Shared divider: first the pulse count, then the half period
  // --------------------------------------------------------------------------
  logic divStart_ff;
  logic [2*WW-1:0] divNum_ff;
  logic [WW-1:0] divDen_ff;
  logic divDone;
  logic [2*WW-1:0] divQuot;

  hpf_divider #(.NUM_W(2*WW), .DEN_W(WW)) u_div (
    .core_clk(core_clk),
    .reset(reset),
    .start(divStart_ff),
    .dividend(divNum_ff),
    .divisor(divDen_ff),
    .done(divDone),
    .quotient(divQuot)
  );

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  hpf_pkg::hpf_state_t state_ff;
  logic [1:0] axis_ff;
  logic [WW-1:0] halfCnt_ff;
  logic halfDone;
  logic lastEdge;

  assign halfDone = halfCnt_ff >= workWord_ff[`HPF_WK_HALF] - WW'(1);
  assign lastEdge = pulseOut_ff[axis_ff]
                    && (workWord_ff[`HPF_WK_SENT] + WW'(1) == workWord_ff[`HPF_WK_TARGET]);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff <= hpf_pkg::HPF_IDLE;
      pulsingActive_ff <= 1'b0;
      divStart_ff <= 1'b0;
      divNum_ff <= '0;
      divDen_ff <= '0;
      axis_ff <= '0;
      dirOut_ff <= '0;
    end else begin
      divStart_ff <= 1'b0;
      if (!enable || hwBusy) begin
        state_ff <= hpf_pkg::HPF_IDLE;
        pulsingActive_ff <= 1'b0;
      end else if (sampleTick_ff) begin
        // A late stream is cut off here so the next interval starts clean.
        pulsingActive_ff <= 1'b0;
        if (go) begin
          state_ff <= hpf_pkg::HPF_SCALE;
          divStart_ff <= 1'b1;
          divNum_ff <= scaledIn;
          divDen_ff <= settings.ratioDivisor;
          axis_ff <= outputAxisSel;
          dirOut_ff <= {`HPF_NUM_AXES{1'b0}} | (`HPF_NUM_AXES'(delta[WW-1]) << outputAxisSel);
        end else begin
          state_ff <= hpf_pkg::HPF_IDLE;
        end
      end else begin
        unique case (state_ff)
          hpf_pkg::HPF_IDLE: begin
          end
          hpf_pkg::HPF_SCALE: begin
            if (divDone) begin
              if (divQuot == '0) begin
                state_ff <= hpf_pkg::HPF_IDLE;
              end else begin
                state_ff <= hpf_pkg::HPF_PERIOD;
                divStart_ff <= 1'b1;
                divNum_ff <= HALF_CLK;
                divDen_ff <= settings.outputSpeed;
              end
            end
          end
          hpf_pkg::HPF_PERIOD: begin
            if (divDone) begin
              state_ff <= hpf_pkg::HPF_PULSE;
              pulsingActive_ff <= 1'b1;
            end
          end
          hpf_pkg::HPF_PULSE: begin
            if (halfDone && lastEdge) begin
              state_ff <= hpf_pkg::HPF_IDLE;
              pulsingActive_ff <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Working words and pulse generation
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < `HPF_WORK_WORDS; i++) begin
        workWord_ff[i] <= '0;
      end
      halfCnt_ff <= '0;
      pulseOut_ff <= '0;
    end else begin
      if (sampleTick_ff) begin
        workWord_ff[`HPF_WK_PREV] <= curCount;
      end
      if (state_ff == hpf_pkg::HPF_SCALE && divDone) begin
        // Anything past 32 bits saturates; the remainder is simply dropped.
        workWord_ff[`HPF_WK_TARGET] <= (divQuot[2*WW-1:WW] != '0) ? '1
                                       : divQuot[WW-1:0];
      end
      if (state_ff == hpf_pkg::HPF_PERIOD && divDone) begin
        workWord_ff[`HPF_WK_HALF] <= (divQuot[2*WW-1:WW] != '0) ? '1
                                     : ((divQuot[WW-1:0] == '0) ? WW'(1) : divQuot[WW-1:0]);
        workWord_ff[`HPF_WK_SENT] <= '0;
        halfCnt_ff <= '0;
      end
      if (state_ff == hpf_pkg::HPF_PULSE && pulsingActive_ff && !sampleTick_ff
          && enable && !hwBusy) begin
        if (halfDone) begin
          halfCnt_ff <= '0;
          pulseOut_ff[axis_ff] <= ~pulseOut_ff[axis_ff];
          if (pulseOut_ff[axis_ff]) begin
            workWord_ff[`HPF_WK_SENT] <= workWord_ff[`HPF_WK_SENT] + WW'(1);
          end
        end else begin
          halfCnt_ff <= halfCnt_ff + WW'(1);
        end
      end else begin
        pulseOut_ff <= '0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  localparam int SAMPLE_CYCLES = SUB_TICK_CYCLES * SUBTICKS_PER_SAMPLE;
  logic [31:0] sinceTick_ff;
  logic seenTick_ff;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sinceTick_ff <= '0;
      seenTick_ff <= 1'b0;
    end else begin
      sinceTick_ff <= sampleTick_ff ? 32'h0000_0001 : sinceTick_ff + 32'h0000_0001;
      seenTick_ff <= seenTick_ff | sampleTick_ff;
    end
  end

  property p_tickPeriod;
    @(posedge core_clk) disable iff (reset)
    (sampleTick_ff && seenTick_ff) |-> (sinceTick_ff == 32'(SAMPLE_CYCLES));
  endproperty
  a_tickPeriod: assert property (p_tickPeriod) else $error("sample period wrong");

  property p_sampleLatch;
    @(posedge core_clk) disable iff (reset)
    sampleTick_ff |=> workWord_ff[`HPF_WK_PREV] == $past(curCount);
  endproperty
  a_sampleLatch: assert property (p_sampleLatch) else $error("count not latched");

  property p_noDeltaIdle;
    @(posedge core_clk) disable iff (reset)
    (sampleTick_ff && delta == '0) |=> (state_ff == hpf_pkg::HPF_IDLE) && !pulsingActive_ff;
  endproperty
  a_noDeltaIdle: assert property (p_noDeltaIdle) else $error("ran with no input");

  property p_scaleResult;
    @(posedge core_clk) disable iff (reset)
    (state_ff == hpf_pkg::HPF_SCALE && divDone && divQuot[2*WW-1:WW] == '0)
    |=> workWord_ff[`HPF_WK_TARGET] == $past(divQuot[WW-1:0]);
  endproperty
  a_scaleResult: assert property (p_scaleResult) else $error("scaled count wrong");

  property p_zeroDivisor;
    @(posedge core_clk) disable iff (reset)
    (sampleTick_ff && settings.ratioDivisor == '0) |=> state_ff == hpf_pkg::HPF_IDLE;
  endproperty
  a_zeroDivisor: assert property (p_zeroDivisor) else $error("ran with zero divisor");

  property p_axisOnly;
    @(posedge core_clk) disable iff (reset)
    (pulseOut_ff & ~(`HPF_NUM_AXES'(1) << axis_ff)) == '0;
  endproperty
  a_axisOnly: assert property (p_axisOnly) else $error("pulse on wrong axis");

  property p_sentBound;
    @(posedge core_clk) disable iff (reset)
    pulsingActive_ff |-> workWord_ff[`HPF_WK_SENT] < workWord_ff[`HPF_WK_TARGET];
  endproperty
  a_sentBound: assert property (p_sentBound) else $error("too many pulses");

  property p_busyStops;
    @(posedge core_clk) disable iff (reset)
    (hwBusy || !enable) |=> (state_ff == hpf_pkg::HPF_IDLE) ##1 (pulseOut_ff == '0);
  endproperty
  a_busyStops: assert property (p_busyStops) else $error("ran while claimed");

  property p_activeMatches;
    @(posedge core_clk) disable iff (reset)
    pulsingActive_ff == (state_ff == hpf_pkg::HPF_PULSE);
  endproperty
  a_activeMatches: assert property (p_activeMatches) else $error("active flag wrong");

endmodule // hpf_follower

// ===== verilog/hpf_consts.svh
`ifndef HPF_CONSTS_SVH
`define HPF_CONSTS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define HPF_CLK_MHZ 200
`define HPF_CLK_HZ 200000000
`define HPF_SAMPLE_MS 50
`define HPF_SUBTICK_US 100
`define HPF_US_PER_MS 1000
`define HPF_SUBTICK_CYCLES (`HPF_SUBTICK_US * `HPF_CLK_MHZ)
`define HPF_SUBTICKS_PER_SAMPLE ((`HPF_SAMPLE_MS * `HPF_US_PER_MS) / `HPF_SUBTICK_US)

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define HPF_NUM_COUNTERS 8
`define HPF_NUM_AXES 4
`define HPF_WORD_W 32
`define HPF_WORK_WORDS 4

// ----------------------------------------------------------------------------
// Working word slots
// ----------------------------------------------------------------------------
`define HPF_WK_PREV 0
`define HPF_WK_TARGET 1
`define HPF_WK_HALF 2
`define HPF_WK_SENT 3

`endif

// ===== verilog/hpf_pkg.sv
`include "hpf_consts.svh"

package hpf_pkg;

  typedef enum logic [1:0] {
    HPF_IDLE   = 2'b00,
    HPF_SCALE  = 2'b01,
    HPF_PERIOD = 2'b11,
    HPF_PULSE  = 2'b10
  } hpf_state_t;

  typedef struct packed {
    logic [`HPF_WORD_W-1:0] ratioMultiplicand;
    logic [`HPF_WORD_W-1:0] ratioDivisor;
    logic [`HPF_WORD_W-1:0] outputSpeed;
  } hpf_settings_t;

  typedef logic [`HPF_NUM_COUNTERS-1:0][`HPF_WORD_W-1:0] hpf_counters_t;

endpackage

// ===== verilog/hpf_divider.sv
`timescale 1ns/1ps

module hpf_divider #(
  parameter int NUM_W = 64,
  parameter int DEN_W = 32
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [NUM_W-1:0] dividend,
  input wire logic [DEN_W-1:0] divisor,
  output logic done,
  output logic [NUM_W-1:0] quotient
);

  localparam int CNT_W = $clog2(NUM_W + 1);

  generate
    if (NUM_W < 2 || DEN_W < 1) begin : g_bad
      $error("hpf_divider: unsupported widths");
    end
  endgenerate

  logic [DEN_W:0] rem_ff;
  logic [NUM_W-1:0] quo_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic done_ff;
  logic [DEN_W:0] shifted;
  logic fits;

  assign shifted = {rem_ff[DEN_W-1:0], quo_ff[NUM_W-1]};
  assign fits = shifted >= {1'b0, divisor};
  assign done = done_ff;
  assign quotient = quo_ff;

  // Restoring division, one quotient bit a cycle; the result truncates.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rem_ff <= '0;
      quo_ff <= '0;
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else if (start) begin
      rem_ff <= '0;
      quo_ff <= dividend;
      cnt_ff <= CNT_W'(NUM_W);
      done_ff <= 1'b0;
    end else if (cnt_ff != '0) begin
      rem_ff <= fits ? (shifted - {1'b0, divisor}) : shifted;
      quo_ff <= {quo_ff[NUM_W-2:0], fits};
      cnt_ff <= cnt_ff - CNT_W'(1);
      done_ff <= (cnt_ff == CNT_W'(1));
    end else begin
      done_ff <= 1'b0;
    end
  end

endmodule // hpf_divider

// ===== test/hpf_wheel_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Handwheel counters on one side, motor pulse drive on the other
// ----------------------------------------------------------------------------
module hpf_wheel_model (
  input wire logic core_clk,
  input wire logic addStb,
  input wire logic [2:0] addIdx,
  input wire logic [31:0] addAmt,
  input wire logic [3:0] pulseOut,
  input wire logic pulsingActive,
  output hpf_pkg::hpf_counters_t hscCounts,
  output logic [3:0][31:0] pulseCnt,
  output logic [31:0] activeCnt,
  output logic [31:0] strayCnt
);
  logic [3:0] pulsePrev;

  // Distinct start values, so that following the wrong counter shows as a bogus delta.
  initial begin
    for (int i = 0; i < 8; i++) begin
      hscCounts[i] = 32'h1000_0000 + 32'(i) * 32'h0001_0111;
    end
    pulseCnt = '0;
    activeCnt = '0;
    strayCnt = '0;
    pulsePrev = '0;
  end

  always @(posedge core_clk) begin
    if (addStb) begin
      hscCounts[addIdx] <= hscCounts[addIdx] + addAmt;
    end
  end

  // The drive counts rising edges; an edge seen without the active flag is stray.
  always @(posedge core_clk) begin
    pulsePrev <= pulseOut;
    if (pulsingActive === 1'b1) begin
      activeCnt <= activeCnt + 32'h1;
    end
    for (int a = 0; a < 4; a++) begin
      if (pulseOut[a] === 1'b1 && pulsePrev[a] === 1'b0) begin
        pulseCnt[a] <= pulseCnt[a] + 32'h1;
        if (pulsingActive !== 1'b1) begin
          strayCnt <= strayCnt + 32'h1;
        end
      end
    end
  end
endmodule // hpf_wheel_model

// ===== test/handwheel_pulse_follower_bench.sv
`timescale 1ns/1ps

module handwheel_pulse_follower_bench;
  localparam int SUB = 20;
  localparam int PER = 20;
  localparam int INTERVAL = SUB * PER;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic enable = 1'b0;
  logic hwBusy = 1'b0;
  logic [2:0] sourceCounterSel = 3'h0;
  logic [1:0] outputAxisSel = 2'h0;
  // A half period of one cycle keeps even the largest ratio inside one interval.
  hpf_pkg::hpf_settings_t settings = '{32'h1, 32'h1, 32'h05f5_e100};
  hpf_pkg::hpf_counters_t hscCounts;
  logic [3:0] pulseOut_ff;
  logic [3:0] dirOut_ff;
  logic pulsingActive_ff;
  logic sampleTick_ff;
  logic addStb = 1'b0;
  logic [2:0] addIdx = 3'h0;
  logic [31:0] addAmt = 32'h0;
  logic [3:0][31:0] pulseCnt;
  logic [31:0] activeCnt;
  logic [31:0] strayCnt;
  int fails = 0;
  int num_checks = 0;
  int gap = -1;
  logic [31:0] activeBase;

  hpf_follower #(.SUB_TICK_CYCLES(SUB), .SUBTICKS_PER_SAMPLE(PER)) dut (
    .core_clk(core_clk), .reset(reset), .enable(enable), .hwBusy(hwBusy),
    .sourceCounterSel(sourceCounterSel), .outputAxisSel(outputAxisSel),
    .hscCounts(hscCounts), .settings(settings), .pulseOut_ff(pulseOut_ff),
    .dirOut_ff(dirOut_ff), .pulsingActive_ff(pulsingActive_ff),
    .sampleTick_ff(sampleTick_ff));

  hpf_wheel_model partner (
    .core_clk(core_clk), .addStb(addStb), .addIdx(addIdx), .addAmt(addAmt),
    .pulseOut(pulseOut_ff), .pulsingActive(pulsingActive_ff), .hscCounts(hscCounts),
    .pulseCnt(pulseCnt), .activeCnt(activeCnt), .strayCnt(strayCnt));

  always #2.5 core_clk = ~core_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Returns at the edge where the design takes its sample; the watchdog bounds it.
  task automatic wait_tick;
    @(posedge core_clk iff sampleTick_ff === 1'b1);
  endtask

  // Interval one settles the previous count with the new selector, interval two
  // carries the handwheel turn, interval three holds the resulting train.
  task automatic run(input string name, input logic [2:0] sel, input logic [1:0] axis,
      input logic [31:0] amt, input logic [31:0] mul, input logic [31:0] dv,
      input logic en, input logic busy, input logic [31:0] expN, input logic expDir);
    logic [3:0][31:0] base;
    logic [31:0] act0;
    sourceCounterSel <= sel;
    outputAxisSel <= axis;
    settings.ratioMultiplicand <= mul;
    settings.ratioDivisor <= dv;
    enable <= 1'b0;
    hwBusy <= 1'b0;
    wait_tick;
    addIdx <= sel;
    addAmt <= amt;
    addStb <= 1'b1;
    enable <= en;
    hwBusy <= busy;
    @(posedge core_clk);
    addStb <= 1'b0;
    wait_tick;
    base = pulseCnt;
    act0 = activeCnt;
    wait_tick;
    for (int a = 0; a < 4; a++) begin
      check(pulseCnt[a] - base[a], (2'(a) == axis) ? expN : 32'h0);
    end
    check({31'h0, (activeCnt - act0) != 32'h0}, {31'h0, expN != 32'h0});
    if (expN != 32'h0) begin
      check({31'h0, dirOut_ff[axis]}, {31'h0, expDir});
    end
    $display("test %s done", name);
  endtask

  // Consecutive ticks must lie exactly one interval apart.
  always @(posedge core_clk) begin
    if (reset) begin
      gap <= -1;
    end else if (sampleTick_ff === 1'b1) begin
      if (gap >= 0) begin
        check(32'(gap + 1), 32'(INTERVAL));
      end
      gap <= 0;
    end else if (gap >= 0) begin
      gap <= gap + 1;
    end
  end

  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    check({22'h0, dirOut_ff, sampleTick_ff, pulseOut_ff, pulsingActive_ff}, 32'h0);
    wait_tick;
    run("ratio", 3'h3, 2'h2, 32'h7, 32'h3, 32'h2, 1'b1, 1'b0, 32'ha, 1'b0);
    run("large", 3'h3, 2'h2, 32'h9, 32'hc8, 32'h64, 1'b1, 1'b0, 32'h12, 1'b0);
    run("still", 3'h3, 2'h1, 32'h0, 32'h3, 32'h1, 1'b1, 1'b0, 32'h0, 1'b0);
    run("claimed", 3'h5, 2'h1, 32'h6, 32'h1, 32'h1, 1'b1, 1'b1, 32'h0, 1'b0);
    run("disabled", 3'h5, 2'h1, 32'h6, 32'h1, 32'h1, 1'b0, 1'b0, 32'h0, 1'b0);
    run("reverse", 3'h1, 2'h3, 32'hffff_fffb, 32'h1, 32'h1, 1'b1, 1'b0, 32'h5, 1'b1);
    run("trunc", 3'h1, 2'h0, 32'h3, 32'h1, 32'h4, 1'b1, 1'b0, 32'h0, 1'b0);
    run("residue", 3'h1, 2'h0, 32'h1, 32'h1, 32'h4, 1'b1, 1'b0, 32'h0, 1'b0);
    run("zero_div", 3'h1, 2'h0, 32'h5, 32'h1, 32'h0, 1'b1, 1'b0, 32'h0, 1'b0);
    settings.outputSpeed <= 32'h0;
    run("no_speed", 3'h2, 2'h1, 32'h3, 32'h1, 32'h1, 1'b1, 1'b0, 32'h0, 1'b0);
    // A quarter of the fast speed gives four-cycle halves, so the active time shows the spacing.
    settings.outputSpeed <= 32'h017d_7840;
    activeBase = activeCnt;
    run("slow", 3'h2, 2'h1, 32'h4, 32'h1, 32'h1, 1'b1, 1'b0, 32'h4, 1'b0);
    check(activeCnt - activeBase, 32'h20);
    settings.outputSpeed <= 32'h05f5_e100;
    for (int i = 0; i < 8; i++) begin
      run("select", 3'(i), 2'(i), 32'(i + 1), 32'h1, 32'h1, 1'b1, 1'b0, 32'(i + 1), 1'b0);
    end
    check(strayCnt, 32'h0);
    tally_and_finish;
  end

  initial begin
    // Nineteen runs of three intervals each, with room to spare.
    repeat (25 * 3 * INTERVAL) @(posedge core_clk);
    fails++;
    tally_and_finish;
  end
endmodule // handwheel_pulse_follower_bench
